// ==== core/nvmc_pkg.sv ====
// package: register map, field positions and timing of the nonvolatile access controller
package nvmc_pkg;
  // register indices on the plain register port
  localparam logic [2:0] NVMC_ADDR_CTRL = 3'h0;
  localparam logic [2:0] NVMC_ADDR_UNLOCK = 3'h1;
  localparam logic [2:0] NVMC_ADDR_DATL = 3'h2;
  localparam logic [2:0] NVMC_ADDR_DATH = 3'h3;
  localparam logic [2:0] NVMC_ADDR_ADRL = 3'h4;
  localparam logic [2:0] NVMC_ADDR_ADRH = 3'h5;
  localparam logic [2:0] NVMC_ADDR_STAT = 3'h6;
  localparam logic [2:0] NVMC_ADDR_CFG = 3'h7;
  // control register bit positions
  localparam int NVMC_B_RD = 0;
  localparam int NVMC_B_WR = 1;
  localparam int NVMC_B_WEN = 2;
  localparam int NVMC_B_WERR = 3;
  localparam int NVMC_B_LWLO = 5;
  localparam int NVMC_B_CSEL = 6;
  localparam int NVMC_B_PGSEL = 7;
  // status register bit positions
  localparam int NVMC_B_DONE = 0;
  localparam int NVMC_B_PWRT = 1;
  localparam int NVMC_B_REJ = 2;
  // config register bit positions
  localparam int NVMC_B_DPROT = 0;
  localparam int NVMC_B_PPROT = 1;
  localparam int NVMC_B_SWP_LO = 2;
  localparam logic [7:0] NVMC_UNLOCK1 = 8'h55;
  localparam logic [7:0] NVMC_UNLOCK2 = 8'hAA;
  localparam logic [7:0] NVMC_ZERO8 = 8'h00;
  localparam logic [13:0] NVMC_LATCH_ERASED = 14'h3FFF;
  localparam int NVMC_LATCHES = 32;
  localparam int NVMC_ROW_WORDS = 32;
  localparam int NVMC_WORD_W = 14;
  localparam int NVMC_PADDR_W = 15;
  // timing
  localparam int NVMC_CLK_HZ = 20_000_000;
  localparam int NVMC_PWRT_MS = 64;
  localparam int NVMC_PWRT_CYC = NVMC_PWRT_MS * (NVMC_CLK_HZ / 1000);
  localparam int NVMC_WRITE_CYC = 40_000;
  typedef enum logic [2:0]
  {
    NVMC_IDLE = 3'b000,
    NVMC_PRD1 = 3'b001,
    NVMC_PRD2 = 3'b010,
    NVMC_EEWR = 3'b011,
    NVMC_PGWR = 3'b100
  } nvmc_state_t;
  typedef enum logic [1:0]
  {
    NVMC_UL_NONE = 2'b00,
    NVMC_UL_HAVE55 = 2'b01,
    NVMC_UL_ARMED = 2'b10
  } nvmc_unlock_t;
endpackage

// ==== core/nvmc_ram.sv ====
// storage module: synchronous write, registered read data
`timescale 1ns/100ps
module nvmc_ram #(
  parameter int AW = 8,
  parameter int DW = 8,
  parameter logic [DW-1:0] INIT = '0
)
(
  input wire logic clk_sys, // system clock
  input wire logic we, // write strobe
  input wire logic [AW-1:0] waddr, // write address
  input wire logic [DW-1:0] wdata, // write data
  input wire logic [AW-1:0] raddr, // read address
  output logic [DW-1:0] rdata // registered read data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  initial
  begin
    for (int i = 0; i < (1 << AW); i++)
    begin
      mem[i] = INIT;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ==== core/nvmc_ctrl.sv ====
// nonvolatile access controller: data EEPROM byte access, program read, write latches
// ******************************************************************
// Overview of operation
// R1 - software loads low address, clears both selects, then sets read start
// R2 - data EEPROM byte appears in low data register the next cycle
// R3 - low data holds read value until next read or software write
// R4 - data EEPROM reads ignore the data protect bit
// R5 - software loads address and data before each byte write
// R6 - write starts only after 55h then AAh then write start
// R7 - software should disable interrupts around the unlock sequence
// R8 - write start refused unless write enable already set
// R9 - hardware never clears write enable; only software or power-up
// R10 - clearing write enable does not abort a started write
// R11 - on completion write start clears and done flag sets until cleared
// R12 - power-up clears write enable and blocks writes for 64 ms
// R13 - with data protect at zero, external programmer cannot access EEPROM
// R14 - program memory rows are 32 words of 14 bits
// R15 - program writes into a write-protected segment are rejected
// R16 - 32 hidden write latches filled through the data register pair
// R17 - software loads address pair, clears config, sets program select, reads
// R18 - program read fetches in second cycle; word lands in data pair
// R19 - software follows a program read with two no-operations
// R20 - program reads ignore the program protect bit
// R21 - read and write start bits cannot be cleared by software
// R22 - reset during a write sets the write error flag
// R23 - unlock register always reads zero
// R24 - reset selects data EEPROM; clear program select means data EEPROM
// R25 - write duration timed by a counter with parameter terminal count
// R26 - any other step between unlock writes breaks the sequence; code breaks it only on other register writes, not on reads
// ******************************************************************
`timescale 1ns/100ps
module nvmc_ctrl
  import nvmc_pkg::*;
#(
  parameter int PWRT_CYC = NVMC_PWRT_CYC,
  parameter int WRITE_CYC = NVMC_WRITE_CYC
)
(
  input wire logic clk_sys, // system clock
  input wire logic rst, // synchronous reset, any source
  input wire logic por, // power-up marker, high with rst at power-on
  input wire logic [2:0] reg_addr, // register index
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic ext_prog_req, // external programmer access request
  output logic ext_prog_deny, // external access refused
  output logic [NVMC_PADDR_W-1:0] pm_addr, // program array address
  input wire logic [NVMC_WORD_W-1:0] pm_rdata, // program array word
  output logic pm_rd, // program array fetch pulse
  output logic pm_row_wr, // latch block commit pulse
  output logic [NVMC_LATCHES*NVMC_WORD_W-1:0] pm_latch, // latch contents
  output logic cpu_stall // ignore the instruction in this cycle
);
  // ******************************************************************
  // state
  // ******************************************************************
  typedef struct packed {
    nvmc_state_t st;
    nvmc_unlock_t ul;
    logic [7:0] ctrl;
    logic [7:0] datl;
    logic [5:0] dath;
    logic [7:0] adrl;
    logic [6:0] adrh;
    logic done;
    logic rej;
    logic [3:0] cfg;
    logic [25:0] pwrt;
    logic [17:0] wcnt;
    logic [7:0] rdata;
    logic rd_dat;
  } nvmc_regs_t;

  nvmc_regs_t q_r, q_nxt;
  logic [NVMC_WORD_W-1:0] latch_r [0:NVMC_LATCHES-1];
  logic ee_we;
  logic [7:0] ee_q;
  logic latch_ld, latch_clr;
  logic wr_set, wr_inprog, pm_prot;
  logic [1:0] swp_fld;

  nvmc_ram #(.AW(8), .DW(8), .INIT(8'hFF)) u_ee
  (
    .clk_sys(clk_sys),
    .we(ee_we),
    .waddr(q_r.adrl),
    .wdata(q_r.datl),
    .raddr(q_nxt.adrl),
    .rdata(ee_q)
  );

  // ******************************************************************
  // next state
  // ******************************************************************
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.rd_dat = 1'b0;
    ee_we = 1'b0;
    latch_ld = 1'b0;
    latch_clr = 1'b0;
    pm_rd = 1'b0;
    pm_row_wr = 1'b0;
    swp_fld = q_r.cfg[NVMC_B_SWP_LO +: 2];
    wr_inprog = (q_r.st == NVMC_EEWR) || (q_r.st == NVMC_PGWR);
    // lower fraction of program space protected per field value
    case (swp_fld)
      2'b11: pm_prot = 1'b0;
      2'b10: pm_prot = (q_r.adrh[6:4] == 3'b000); // R15
      2'b01: pm_prot = (q_r.adrh[6:5] == 2'b00); // R15
      default: pm_prot = 1'b1; // R15
    endcase
    wr_set = 1'b0;
    if (q_r.pwrt != '0)
    begin
      q_nxt.pwrt = q_r.pwrt - 26'd1;
    end
    if (reg_wr)
    begin
      if (reg_addr == NVMC_ADDR_UNLOCK)
      begin
        if (reg_wdata == NVMC_UNLOCK1) // R6
          q_nxt.ul = NVMC_UL_HAVE55;
        else if (reg_wdata == NVMC_UNLOCK2 && q_r.ul == NVMC_UL_HAVE55)
          q_nxt.ul = NVMC_UL_ARMED;
        else
          q_nxt.ul = NVMC_UL_NONE; // R26
      end
      else
      begin
        q_nxt.ul = NVMC_UL_NONE; // R26
      end
      if (reg_addr == NVMC_ADDR_CTRL)
      begin
        q_nxt.ctrl[NVMC_B_WEN] = reg_wdata[NVMC_B_WEN]; // R9 R10
        q_nxt.ctrl[NVMC_B_LWLO] = reg_wdata[NVMC_B_LWLO];
        q_nxt.ctrl[NVMC_B_CSEL] = reg_wdata[NVMC_B_CSEL];
        q_nxt.ctrl[NVMC_B_PGSEL] = reg_wdata[NVMC_B_PGSEL]; // R24
        q_nxt.ctrl[NVMC_B_WERR] = q_r.ctrl[NVMC_B_WERR] & reg_wdata[NVMC_B_WERR];
        // start bits: set only, never cleared by software
        if (reg_wdata[NVMC_B_WR] && q_r.ul == NVMC_UL_ARMED && q_r.ctrl[NVMC_B_WEN]
            && !wr_inprog && q_r.pwrt == '0) // R6 R8 R12 R21
          wr_set = 1'b1;
        if (reg_wdata[NVMC_B_RD] && q_r.st == NVMC_IDLE) // R21
        begin
          q_nxt.ctrl[NVMC_B_RD] = 1'b1;
          if (reg_wdata[NVMC_B_PGSEL] && !reg_wdata[NVMC_B_CSEL])
          begin
            q_nxt.st = NVMC_PRD1; // R18 R20
          end
          else if (!reg_wdata[NVMC_B_PGSEL] && !reg_wdata[NVMC_B_CSEL])
          begin
            q_nxt.rd_dat = 1'b1; // R2 R4
          end
          else
          begin
            q_nxt.ctrl[NVMC_B_RD] = 1'b0;
          end
        end
      end
      if (reg_addr == NVMC_ADDR_DATL)
        q_nxt.datl = reg_wdata; // R3
      if (reg_addr == NVMC_ADDR_DATH)
        q_nxt.dath = reg_wdata[5:0];
      if (reg_addr == NVMC_ADDR_ADRL)
        q_nxt.adrl = reg_wdata;
      if (reg_addr == NVMC_ADDR_ADRH)
        q_nxt.adrh = reg_wdata[6:0];
      if (reg_addr == NVMC_ADDR_STAT)
      begin
        q_nxt.done = q_r.done & reg_wdata[NVMC_B_DONE];
        q_nxt.rej = q_r.rej & reg_wdata[NVMC_B_REJ];
      end
      if (reg_addr == NVMC_ADDR_CFG)
        q_nxt.cfg = reg_wdata[3:0];
    end
    if (wr_set)
    begin
      if (!q_r.ctrl[NVMC_B_PGSEL])
      begin
        q_nxt.ctrl[NVMC_B_WR] = 1'b1;
        q_nxt.st = NVMC_EEWR;
        q_nxt.wcnt = '0;
      end
      else if (pm_prot)
      begin
        q_nxt.rej = 1'b1; // R15
      end
      else if (q_r.ctrl[NVMC_B_LWLO])
      begin
        latch_ld = 1'b1; // R16
      end
      else
      begin
        latch_ld = 1'b1;
        q_nxt.ctrl[NVMC_B_WR] = 1'b1;
        q_nxt.st = NVMC_PGWR;
        q_nxt.wcnt = '0;
      end
    end
    case (q_r.st)
      NVMC_PRD1:
      begin
        q_nxt.st = NVMC_PRD2;
        pm_rd = 1'b1;
      end
      NVMC_PRD2:
      begin
        q_nxt.datl = pm_rdata[7:0]; // R18
        q_nxt.dath = pm_rdata[13:8];
        q_nxt.ctrl[NVMC_B_RD] = 1'b0;
        q_nxt.st = NVMC_IDLE;
      end
      NVMC_EEWR, NVMC_PGWR:
      begin
        q_nxt.wcnt = q_r.wcnt + 18'd1;
        if (q_r.wcnt == 18'(WRITE_CYC - 1)) // R25
        begin
          ee_we = (q_r.st == NVMC_EEWR);
          pm_row_wr = (q_r.st == NVMC_PGWR);
          latch_clr = (q_r.st == NVMC_PGWR);
          q_nxt.ctrl[NVMC_B_WR] = 1'b0; // R11
          q_nxt.done = 1'b1; // R11
          q_nxt.st = NVMC_IDLE;
        end
      end
      default:
      begin
      end
    endcase
    if (q_r.rd_dat)
    begin
      q_nxt.ctrl[NVMC_B_RD] = 1'b0;
      if (!(reg_wr && reg_addr == NVMC_ADDR_DATL))
        q_nxt.datl = ee_q; // R2
    end
  end

  // ******************************************************************
  // registers
  // ******************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      q_r.st <= NVMC_IDLE;
      q_r.ul <= NVMC_UL_NONE;
      // write enable kept across warm reset, error records an interrupted write
      q_r.ctrl <= por ? NVMC_ZERO8 : {4'b0000, (q_r.ctrl[NVMC_B_WERR] | wr_inprog),
        q_r.ctrl[NVMC_B_WEN], 2'b00}; // R9 R12 R22 R24
      q_r.datl <= NVMC_ZERO8;
      q_r.dath <= '0;
      q_r.adrl <= NVMC_ZERO8;
      q_r.adrh <= '0;
      q_r.done <= 1'b0;
      q_r.rej <= 1'b0;
      q_r.cfg <= 4'hF;
      q_r.pwrt <= por ? 26'(PWRT_CYC) : 26'd0; // R12
      q_r.wcnt <= '0;
      q_r.rdata <= NVMC_ZERO8;
      q_r.rd_dat <= 1'b0;
    end
    else
    begin
      q_r <= q_nxt;
      if (reg_rd)
      begin
        if (reg_addr == NVMC_ADDR_CTRL)
          q_r.rdata <= q_r.ctrl;
        else if (reg_addr == NVMC_ADDR_UNLOCK)
          q_r.rdata <= NVMC_ZERO8; // R23
        else if (reg_addr == NVMC_ADDR_DATL)
          // byte of a read started last cycle is forwarded, so the next access sees it
          q_r.rdata <= q_r.rd_dat ? ee_q : q_r.datl; // R2
        else if (reg_addr == NVMC_ADDR_DATH)
          q_r.rdata <= {2'b00, q_r.dath};
        else if (reg_addr == NVMC_ADDR_ADRL)
          q_r.rdata <= q_r.adrl;
        else if (reg_addr == NVMC_ADDR_ADRH)
          q_r.rdata <= {1'b0, q_r.adrh};
        else if (reg_addr == NVMC_ADDR_STAT)
          q_r.rdata <= {5'b0_0000, q_r.rej, (q_r.pwrt != '0), q_r.done};
        else
          q_r.rdata <= {4'h0, q_r.cfg};
      end
    end
  end

  // ******************************************************************
  // write latches, one per word of the aligned block
  // ******************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NVMC_LATCHES; gi++)
    begin : g_latch
      always_ff @(posedge clk_sys)
      begin
        if (rst || latch_clr)
          latch_r[gi] <= NVMC_LATCH_ERASED;
        else if (latch_ld && q_r.adrl[4:0] == 5'(gi))
          latch_r[gi] <= {q_r.dath, q_r.datl}; // R16
      end
      assign pm_latch[gi*NVMC_WORD_W +: NVMC_WORD_W] = latch_r[gi];
    end
  endgenerate

  // row base for commit, row of 32 words is the erase unit
  assign pm_addr = (q_r.st == NVMC_PGWR) ? {q_r.adrh, q_r.adrl[7:5], 5'b0_0000}
                                         : {q_r.adrh, q_r.adrl}; // R14
  assign cpu_stall = (q_r.st == NVMC_PRD1); // R18
  assign ext_prog_deny = ext_prog_req & ~q_r.cfg[NVMC_B_DPROT]; // R13
  assign reg_rdata = q_r.rdata;
endmodule

// ==== verif/nvmc_pm_model.sv ====
// program array model answering the fetch pulse
`timescale 1ns/100ps
module nvmc_pm_model
  import nvmc_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic pm_rd, // fetch pulse
  input wire logic [NVMC_PADDR_W-1:0] pm_addr, // word address
  output logic [NVMC_WORD_W-1:0] pm_rdata // fetched word
);
  // ****
  // array
  // ****
  logic [NVMC_WORD_W-1:0] word_r;
  // word good only in the cycle after the fetch; inverted later so a late sample shows
  always_ff @(posedge clk_sys)
  begin
    if (pm_rd)
      word_r <= pm_addr[13:0] ^ 14'h1A5C;
    else
      word_r <= ~word_r;
  end
  assign pm_rdata = word_r;
endmodule

// ==== verif/nvmc_ctrl_asserts.sv ====
// port assertions of the nonvolatile access controller
`timescale 1ns/100ps
module nvmc_ctrl_asserts
  import nvmc_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic [2:0] reg_addr, // index
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write
  input wire logic reg_rd, // read
  input wire logic [7:0] reg_rdata, // read data
  input wire logic ext_prog_req, // ext request
  input wire logic ext_prog_deny, // ext refusal
  input wire logic [NVMC_PADDR_W-1:0] pm_addr, // fetch address
  input wire logic pm_rd, // fetch
  input wire logic pm_row_wr, // commit
  input wire logic cpu_stall // stall
);
  // ****
  // bus shadows
  // ****
  logic [7:0] adrl_r;
  logic [7:0] adrh_r;
  logic dprot_r;
  logic ctl_wr;
  logic pg_go;
  logic ee_go;
  assign ctl_wr = reg_wr && reg_addr == NVMC_ADDR_CTRL;
  assign pg_go = ctl_wr && reg_wdata[NVMC_B_RD] && reg_wdata[NVMC_B_PGSEL];
  assign ee_go = ctl_wr && reg_wdata[NVMC_B_RD] && !reg_wdata[NVMC_B_PGSEL];
  // fed from the bus only, so checks never lean on the design's own state
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      dprot_r <= 1'b1;
    else if (reg_wr && reg_addr == NVMC_ADDR_CFG)
      dprot_r <= reg_wdata[NVMC_B_DPROT];
    if (reg_wr && reg_addr == NVMC_ADDR_ADRL)
      adrl_r <= reg_wdata;
    if (reg_wr && reg_addr == NVMC_ADDR_ADRH)
      adrh_r <= reg_wdata;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_unlock_zero: assert property (reg_rd && reg_addr == NVMC_ADDR_UNLOCK |=> reg_rdata == 8'h00)
    else $error("unlock read not zero");
  a_fetch_cause: assert property (pm_rd |-> $past(pg_go))
    else $error("fetch without program read start");
  a_fetch_single: assert property (pm_rd |=> !pm_rd)
    else $error("fetch pulse too long");
  a_stall_pair: assert property (cpu_stall == pm_rd)
    else $error("stall and fetch differ");
  a_fetch_addr: assert property (pm_rd |-> pm_addr == {adrh_r[6:0], adrl_r})
    else $error("fetch address wrong");
  a_ee_nofetch: assert property (ee_go |=> !pm_rd [*2])
    else $error("data read fetched program word");
  a_deny_map: assert property (ext_prog_deny == (ext_prog_req && !dprot_r))
    else $error("external refusal wrong");
  a_row_pulse: assert property (pm_row_wr |=> !pm_row_wr)
    else $error("commit pulse too long");
endmodule
bind nvmc_ctrl nvmc_ctrl_asserts u_chk (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .ext_prog_req, .ext_prog_deny, .pm_addr, .pm_rd, .pm_row_wr, .cpu_stall);

// ==== verif/nvmc_ctrl_tb.sv ====
// self-checking bench of the nonvolatile access controller
`timescale 1ns/100ps
module nvmc_ctrl_tb
  import nvmc_pkg::*;
;
  // ****
  // stimulus
  // ****
  localparam logic [2:0] CT = NVMC_ADDR_CTRL;
  localparam logic [2:0] UL = NVMC_ADDR_UNLOCK;
  localparam logic [2:0] DL = NVMC_ADDR_DATL;
  localparam logic [2:0] ST = NVMC_ADDR_STAT;
  logic clk_sys;
  logic rst = 1'b1;
  logic por = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ext_prog_req = 1'b0;
  logic [7:0] reg_rdata;
  logic ext_prog_deny;
  logic [NVMC_PADDR_W-1:0] pm_addr;
  logic [NVMC_WORD_W-1:0] pm_rdata;
  logic pm_rd;
  logic pm_row_wr;
  logic cpu_stall;
  logic [NVMC_LATCHES*NVMC_WORD_W-1:0] pm_latch;
  int err_count = 0;
  int cmp_count = 0;
  nvmc_ctrl #(.PWRT_CYC(20), .WRITE_CYC(10)) u_dut (.clk_sys, .rst, .por, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .ext_prog_req, .ext_prog_deny, .pm_addr, .pm_rdata, .pm_rd,
    .pm_row_wr, .pm_latch, .cpu_stall);
  nvmc_pm_model u_pm (.clk_sys, .pm_rd, .pm_addr, .pm_rdata);
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic close_out();
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
    end
  endtask
  // strobe stays up until the next task's edge, so writes can run back to back
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask
  task automatic reset_dut(input logic p);
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    rst <= 1'b1;
    por <= p;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    por <= 1'b0;
  endtask
  task automatic wait_clr(input logic [2:0] a, input int b);
    logic [7:0] v;
    for (int i = 0; i < 40; i++)
    begin
      rd(a, v);
      if (v[b] === 1'b0)
        return;
    end
    err_count++;
    $display("MISMATCH t=%0t wait ran out", $time);
    close_out();
  endtask
  task automatic ee_start(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
    wr(NVMC_ADDR_ADRL, a);
    wr(DL, d);
    wr(CT, c & 8'hFD);
    wr(UL, NVMC_UNLOCK1);
    wr(UL, NVMC_UNLOCK2);
    wr(CT, c);
  endtask
  task automatic s_power();
    logic [7:0] v;
    rd(CT, v);
    chk(v, 8'h00);
    rd(ST, v);
    chk(v & 8'h07, 8'h02);
    ee_start(8'h3C, 8'hA5, 8'h06);
    rd(CT, v);
    chk(v, 8'h04);
    wait_clr(ST, NVMC_B_PWRT);
  endtask
  task automatic s_write();
    logic [7:0] v;
    ee_start(8'h3C, 8'hA5, 8'h06);
    rd(CT, v);
    chk(v, 8'h06);
    wr(CT, 8'h00);
    rd(CT, v);
    chk(v, 8'h02);
    wait_clr(CT, NVMC_B_WR);
    rd(ST, v);
    chk(v & 8'h01, 8'h01);
    wr(ST, 8'h00);
    rd(ST, v);
    chk(v & 8'h01, 8'h00);
    wr(DL, 8'h00);
    wr(CT, 8'h01);
    rd(DL, v);
    chk(v, 8'hA5);
    rd(CT, v);
    chk(v & 8'h01, 8'h00);
    rd(DL, v);
    chk(v, 8'hA5);
  endtask
  task automatic s_refuse();
    logic [7:0] v;
    ee_start(8'h10, 8'h77, 8'h02);
    rd(CT, v);
    chk(v, 8'h00);
    wr(CT, 8'h04);
    wr(UL, NVMC_UNLOCK1);
    wr(DL, 8'h77);
    wr(UL, NVMC_UNLOCK2);
    wr(CT, 8'h06);
    rd(CT, v);
    chk(v, 8'h04);
    wr(UL, NVMC_UNLOCK2);
    wr(UL, NVMC_UNLOCK1);
    wr(CT, 8'h06);
    rd(CT, v);
    chk(v, 8'h04);
  endtask
  task automatic s_reset();
    logic [7:0] v;
    ee_start(8'h11, 8'h5A, 8'h06);
    reset_dut(1'b0);
    rd(CT, v);
    chk(v, 8'h0C);
    rd(UL, v);
    chk(v, 8'h00);
  endtask
  task automatic s_prog();
    logic [7:0] v;
    logic [13:0] w;
    w = {6'h1A, 8'h9C} ^ 14'h1A5C;
    wr(NVMC_ADDR_CFG, 8'h00);
    ext_prog_req <= 1'b1;
    wr(NVMC_ADDR_ADRL, 8'h9C);
    wr(NVMC_ADDR_ADRH, 8'h5A);
    wr(CT, 8'h81);
    rd(ST, v);
    rd(DL, v);
    chk(v, w[7:0]);
    rd(NVMC_ADDR_DATH, v);
    chk(v & 8'h3F, {2'b00, w[13:8]});
    chk({7'h00, ext_prog_deny}, 8'h01);
    wr(NVMC_ADDR_ADRL, 8'h3C);
    ext_prog_req <= 1'b0;
    wr(CT, 8'h01);
    rd(DL, v);
    chk(v, 8'hA5);
    for (int k = 0; k < 2; k++)
    begin
      wr(NVMC_ADDR_CFG, k ? 8'h0F : 8'h00);
      wr(ST, 8'h00);
      wr(CT, 8'h84);
      wr(UL, NVMC_UNLOCK1);
      wr(UL, NVMC_UNLOCK2);
      wr(CT, 8'h86);
      wait_clr(CT, NVMC_B_WR);
      rd(ST, v);
      chk(v & 8'h04, k ? 8'h00 : 8'h04);
    end
    chk(pm_latch[28*NVMC_WORD_W +: 8], 8'hFF);
    wr(NVMC_ADDR_DATH, 8'h2B);
    wr(CT, 8'hA4);
    wr(UL, NVMC_UNLOCK1);
    wr(UL, NVMC_UNLOCK2);
    wr(CT, 8'hA6);
    rd(CT, v);
    chk(v, 8'hA4);
    chk(pm_latch[28*NVMC_WORD_W +: 8], 8'hA5);
    chk({2'b00, pm_latch[28*NVMC_WORD_W+8 +: 6]}, 8'h2B);
  endtask
  initial
  begin
    reset_dut(1'b1);
    s_power();
    s_write();
    s_refuse();
    s_reset();
    s_prog();
    close_out();
  end
endmodule
